// ### dv/ext_status_assertions.sv
// Concurrent checks on the extended status word outputs
`timescale 1ns/10ps
module ext_status_assertions #(
   parameter logic [39:0] SILENCE_CYCLES = 40'd50,
   parameter logic [39:0] STATIC_CYCLES  = 40'd200
) (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Measurement and heater inputs
   input wire logic        meas_valid,
   input wire logic [15:0] buf_count,
   input wire logic [15:0] buf_capacity,
   input wire logic [15:0] avg_time_s,
   input wire logic        virtual_temperature_limit,
   input wire logic        heat_criterion,
   input wire logic        heater_on_pin,
   // Telegram side
   input wire logic        telegram_sent,
   input wire logic [31:0] status_word
);
   logic [39:0] quiet_q;
   logic [39:0] fault_q;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Lengths of the current runs without a value and with a static fault cause
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         quiet_q <= 40'h0;
         fault_q <= 40'h0;
      end else begin
         quiet_q <= meas_valid ? 40'h0 : quiet_q + 40'h1;
         fault_q <= (meas_valid && !virtual_temperature_limit) ? 40'h0 : fault_q + 40'h1;
      end
   end

   sequence s_flag_sent;
      telegram_sent && status_word[13];
   endsequence
   sequence s_flag_gone;
      ##2 !status_word[13];
   endsequence

   a_gen_silence: assert property (
      quiet_q > SILENCE_CYCLES + 40'h3 && avg_time_s < 16'h000a |-> status_word[0])
      else $error("general fault missing after silence");
   a_gen_fill: assert property (1'b1 |-> ##2 ($past(avg_time_s, 2) < 16'h000a ||
      status_word[0] == ({$past(buf_count, 2), 1'b0} < {1'b0, $past(avg_time_s, 2)})))
      else $error("general fault wrong for long averaging");
   a_heat_crit: assert property (
      1'b1 |-> ##2 status_word[1] == $past(heat_criterion, 2))
      else $error("heating criterion bit wrong");
   a_heat_on: assert property (
      1'b1 |-> ##4 status_word[2] == $past(heater_on_pin, 4))
      else $error("heater on bit wrong");
   a_static_set: assert property (
      fault_q > STATIC_CYCLES + 40'h4 |-> status_word[4])
      else $error("static fault missing");
   a_fill_full: assert property ((buf_capacity != 16'h0) &&
      ({buf_count, 4'h0} > 20'(buf_capacity) * 20'd15) |-> ##2 status_word[11:8] == 4'hf)
      else $error("fill level not full");
   a_fill_low: assert property (
      {buf_count, 4'h0} <= {4'h0, buf_capacity} |-> ##2 status_word[11:8] == 4'h0)
      else $error("fill level not lowest");
   a_restart_clear: assert property (s_flag_sent |-> s_flag_gone)
      else $error("restart flag not cleared");
   a_reserved_zero: assert property ((status_word & 32'hffff_d0e8) == 32'h0)
      else $error("reserved status bits set");
endmodule

bind ext_status_top ext_status_assertions #(
   .SILENCE_CYCLES(SILENCE_CYCLES),
   .STATIC_CYCLES (STATIC_CYCLES)
) i_chk (.*);

// ### dv/telegram_host.sv
// Host that takes in output telegrams and keeps the status word each carries
`timescale 1ns/10ps
module telegram_host (
   // Clock
   input  wire logic        hclk,
   // Telegram link
   input  wire logic [31:0] status_word,
   output logic             telegram_sent
);
   initial telegram_sent = 1'b0;

   // Sends one telegram for one cycle and returns the word it carried
   task automatic send(output logic [31:0] word);
      telegram_sent <= 1'b1;
      @(posedge hclk);
      word = status_word;
      telegram_sent <= 1'b0;
   endtask
endmodule

// ### dv/test_sensor_extended_status_word.sv
// Self-checking bench for the extended status word block
`timescale 1ns/10ps
module test_sensor_extended_status_word;
   localparam logic [39:0] SIL  = 40'd50;
   localparam logic [39:0] STAT = 40'd200;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        meas_valid;
   logic [15:0] buf_count;
   logic [15:0] buf_capacity;
   logic [15:0] avg_time_s;
   logic        virtual_temperature_limit;
   logic        heat_criterion;
   logic        heater_on_pin;
   logic        telegram_sent;
   logic [31:0] status_word;
   logic        irq;
   logic [31:0] rd;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   ext_status_top #(.SILENCE_CYCLES(SIL), .STATIC_CYCLES(STAT)) i_dut (
      .hsize (3'h2),
      .hready(hreadyout),
      .*
   );
   telegram_host i_host (.*);

   always #5 hclk = ~hclk;

   task automatic test_done;
      $display("compared %0d, mismatched %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One single AHB-Lite transfer; read data lands in rd
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wait_chk(input int n, input logic [31:0] exp);
      repeat (n) @(posedge hclk);
      chk(status_word, exp);
   endtask

   task automatic gen_case(input logic [15:0] a, input logic [15:0] c, input logic [31:0] exp);
      avg_time_s <= a;
      buf_count  <= c;
      wait_chk(3, exp);
   endtask

   task automatic ended(input string name);
      $display("test %s finished", name);
   endtask

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      meas_valid = 1'b1;
      buf_count = 16'h0;
      buf_capacity = 16'd160;
      avg_time_s = 16'd5;
      virtual_temperature_limit = 1'b0;
      heat_criterion = 1'b0;
      heater_on_pin = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, ext_status_pkg::OFS_STATUS_WORD, 32'h0);
      chk(rd, ext_status_pkg::RST_STATUS_WORD);
      chk({30'h0, hreadyout, hresp}, 32'h2);
      ahb(1'b1, ext_status_pkg::OFS_STATUS_WORD, 32'hffff_ffff);
      ahb(1'b0, ext_status_pkg::OFS_STATUS_WORD, 32'h0);
      chk(rd, 32'h0000_2000);
      ahb(1'b0, ext_status_pkg::OFS_IRQ_MASK, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      ended("reset");
      i_host.send(rd);
      chk(rd, 32'h0000_2000);
      wait_chk(3, 32'h0);
      i_host.send(rd);
      chk(rd, 32'h0);
      ahb(1'b1, ext_status_pkg::OFS_IRQ_MASK, 32'h4);
      ahb(1'b0, ext_status_pkg::OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'h4);
      chk({31'h0, irq}, 32'h1);
      ahb(1'b1, ext_status_pkg::OFS_IRQ_STATUS, 32'h4);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      ended("restart");
      heat_criterion <= 1'b1;
      heater_on_pin <= 1'b1;
      wait_chk(6, 32'h6);
      heat_criterion <= 1'b0;
      wait_chk(3, 32'h4);
      heater_on_pin <= 1'b0;
      wait_chk(6, 32'h0);
      ended("heater");
      for (int n = 0; n < 16; n++) begin
         buf_count <= 16'(10 * n + 1);
         wait_chk(3, {20'h0, 4'(n), 8'h0});
         buf_count <= 16'(10 * n + 10);
         wait_chk(3, {20'h0, 4'(n), 8'h0});
      end
      ended("fill");
      gen_case(16'd10, 16'd4, 32'h1);
      gen_case(16'd10, 16'd5, 32'h0);
      gen_case(16'd200, 16'd99, 32'h901);
      gen_case(16'd200, 16'd100, 32'h900);
      ended("average");
      avg_time_s <= 16'd5;
      buf_count <= 16'h0;
      meas_valid <= 1'b0;
      wait_chk(int'(SIL) - 2, 32'h0);
      wait_chk(10, 32'h1);
      meas_valid <= 1'b1;
      wait_chk(3, 32'h0);
      ended("silence");
      virtual_temperature_limit <= 1'b1;
      wait_chk(int'(STAT) - 10, 32'h0);
      wait_chk(20, 32'h10);
      virtual_temperature_limit <= 1'b0;
      wait_chk(3, 32'h0);
      ended("static");
      ahb(1'b0, ext_status_pkg::OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'hb);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b1, ext_status_pkg::OFS_IRQ_STATUS, 32'hf);
      ahb(1'b0, ext_status_pkg::OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'h0);
      ended("events");
      ahb(1'b1, ext_status_pkg::OFS_CONTROL, 32'h1);
      wait_chk(3, 32'h0000_2000);
      i_host.send(rd);
      chk(rd, 32'h0000_2000);
      wait_chk(3, 32'h0);
      chk({31'h0, irq}, 32'h1);
      ended("soft restart");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      chk({31'h0, irq}, 32'h0);
      ahb(1'b0, ext_status_pkg::OFS_STATUS_WORD, 32'h0);
      chk(rd, ext_status_pkg::RST_STATUS_WORD);
      ahb(1'b0, ext_status_pkg::OFS_IRQ_MASK, 32'h0);
      chk(rd, 32'h0);
      ended("second reset");
      test_done();
   end
endmodule

// ### rtl/ext_status_pkg.sv
// Constants shared by the extended status word block
package ext_status_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFS_STATUS_WORD = 8'h00;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h08;
   localparam logic [7:0] OFS_CONTROL     = 8'h0c;

   // Field positions of the extended status word
   localparam int BIT_GEN_FAULT   = 0;
   localparam int BIT_HEAT_CRIT   = 1;
   localparam int BIT_HEAT_ON     = 2;
   localparam int BIT_STATIC      = 4;
   localparam int FILL_LSB        = 8;
   localparam int FILL_MSB        = 11;
   localparam int BIT_RESTART     = 13;

   // Interrupt status and mask bit positions
   localparam int IRQ_GEN_FAULT   = 0;
   localparam int IRQ_STATIC      = 1;
   localparam int IRQ_RESTART_CLR = 2;
   localparam int IRQ_HEAT_CHG    = 3;
   localparam int IRQ_WIDTH       = 4;

   // Control register fields
   localparam int CTRL_SOFT_RESTART = 0;

   // Reset values
   localparam logic [31:0]          RST_STATUS_WORD = 32'h0000_2000;
   localparam logic [IRQ_WIDTH-1:0] RST_IRQ_MASK    = 4'h0;

   // Timing
   localparam longint CLK_HZ          = 100_000_000;
   localparam longint SILENCE_S       = 10;
   localparam longint STATIC_S        = 60;
   localparam int     AVG_SHORT_S     = 10;
   localparam longint SILENCE_CYCLES  = SILENCE_S * CLK_HZ;
   localparam longint STATIC_CYCLES   = STATIC_S * CLK_HZ;
   localparam int     TIMER_W         = 40;
   localparam int     FILL_STEPS      = 16;

   // Restart state
   typedef enum logic [1:0] {
      RUN_RESTART = 2'b01,
      RUN_NORMAL  = 2'b10
   } run_state_e;

endpackage

// ### rtl/ext_status_top.sv
// Extended status word of the wind instrument with an AHB-Lite register slave
//
// Summary of operation
// R1: Short averaging: general fault after ten seconds without a new measured value.
// R2: Long averaging: general fault when buffer holds under half the expected values.
// R3: Bit 1 follows the heater switch-on criterion.
// R4: Bit 2 follows the actual heater state.
// R5: Bit 4 set while a static fault has lasted over one minute.
// R6: Bits 8 to 11 give buffer fill in sixteenths, n meaning above n/16.
// R7: Restart flag bit 13 set after restart, cleared after the first telegram.
// R8: All other status bits always read as zero.
`timescale 1ns/10ps
module ext_status_top #(
   parameter logic [39:0] SILENCE_CYCLES = 40'(ext_status_pkg::SILENCE_CYCLES),
   parameter logic [39:0] STATIC_CYCLES  = 40'(ext_status_pkg::STATIC_CYCLES)
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Measurement side
   input  wire logic        meas_valid,
   input  wire logic [15:0] buf_count,
   input  wire logic [15:0] buf_capacity,
   input  wire logic [15:0] avg_time_s,
   input  wire logic        virtual_temperature_limit,
   // Heater
   input  wire logic        heat_criterion,
   input  wire logic        heater_on_pin,
   // Telegram output
   input  wire logic        telegram_sent,
   output logic [31:0]      status_word,
   // Interrupt
   output logic             irq
);

   // Heater feedback synchroniser
   logic heater_meta_q;
   logic heater_sync_q;

   // Timers
   timer_if silence_if ();
   timer_if nodata_if ();
   timer_if vt_if ();

   // Status fields
   logic                  short_fault;
   logic                  long_fault;
   logic                  gen_fault_d;
   logic                  gen_fault_q;
   logic                  static_fault_d;
   logic                  static_fault_q;
   logic                  heat_crit_q;
   logic                  heat_on_q;
   logic [3:0]            fill_d;
   logic [3:0]            fill_q;
   logic [31:0]           status_word_d;
   logic [31:0]           status_word_q;
   ext_status_pkg::run_state_e run_state_q;
   ext_status_pkg::run_state_e run_state_d;

   // Interrupt registers
   logic [ext_status_pkg::IRQ_WIDTH-1:0] irq_status_q;
   logic [ext_status_pkg::IRQ_WIDTH-1:0] irq_mask_q;
   logic [ext_status_pkg::IRQ_WIDTH-1:0] irq_event;
   logic [ext_status_pkg::IRQ_WIDTH-1:0] irq_clear;
   logic [ext_status_pkg::IRQ_WIDTH-1:0] irq_status_d;
   logic [ext_status_pkg::IRQ_WIDTH-1:0] irq_mask_d;
   logic                                  restart_cleared;

   // Bus state
   logic        acc_valid;
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   logic        soft_restart;
   logic        wr_irq_status;
   logic        wr_irq_mask;
   logic        wr_control;

   // Heater feedback comes from a relay contact outside the clock domain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         heater_meta_q <= 1'b0;
         heater_sync_q <= 1'b0;
      end else begin
         heater_meta_q <= heater_on_pin;
         heater_sync_q <= heater_meta_q;
      end
   end

   // Absence of measured values, short window
   assign silence_if.run = !meas_valid;  // [R1]
   persist_timer #(
      .LIMIT (SILENCE_CYCLES)
   ) u_silence (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tif     (silence_if.timer)
   );

   // Static faults must last strictly longer than the minute
   assign nodata_if.run = !meas_valid;  // [R5]
   persist_timer #(
      .LIMIT (STATIC_CYCLES + 40'h1)
   ) u_nodata (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tif     (nodata_if.timer)
   );

   assign vt_if.run = virtual_temperature_limit;  // [R5]
   persist_timer #(
      .LIMIT (STATIC_CYCLES + 40'h1)
   ) u_vt (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tif     (vt_if.timer)
   );

   // Short averaging watches silence; long averaging watches buffer occupancy
   assign short_fault = silence_if.expired;                         // [R1]
   assign long_fault  = ({buf_count, 1'b0} < {1'b0, avg_time_s});   // [R2]

   // General malfunction depends on the averaging time
   always_comb begin
      gen_fault_d = 1'b0;
      if (avg_time_s < 16'(ext_status_pkg::AVG_SHORT_S)) begin
         gen_fault_d = short_fault;  // [R1]
      end else begin
         gen_fault_d = long_fault;  // [R2]
      end
   end

   assign static_fault_d = nodata_if.expired || vt_if.expired;  // [R5]

   // Fill level: count of thresholds k/16 that the fraction exceeds
   always_comb begin
      logic [19:0] scaled;
      logic [19:0] thresh;
      fill_d = 4'h0;
      scaled = {buf_count, 4'h0};
      thresh = 20'h0;
      for (int k = 1; k < ext_status_pkg::FILL_STEPS; k++) begin
         thresh = 20'(k) * {4'h0, buf_capacity};
         if (buf_capacity != 16'h0 && scaled > thresh) begin
            fill_d = fill_d + 4'h1;  // [R6]
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gen_fault_q    <= 1'b0;
         static_fault_q <= 1'b0;
         fill_q         <= 4'h0;
      end else begin
         gen_fault_q    <= gen_fault_d;
         static_fault_q <= static_fault_d;
         fill_q         <= fill_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         heat_crit_q <= 1'b0;
         heat_on_q   <= 1'b0;
      end else begin
         heat_crit_q <= heat_criterion;  // [R3]
         heat_on_q   <= heater_sync_q;   // [R4]
      end
   end

   // Restart flag: the first telegram still carries it, then it drops
   always_comb begin
      run_state_d = run_state_q;
      case (run_state_q)
         ext_status_pkg::RUN_RESTART: begin
            // A restart request in the same cycle keeps the flag up
            if (telegram_sent && !soft_restart) begin
               run_state_d = ext_status_pkg::RUN_NORMAL;  // [R7]
            end
         end
         ext_status_pkg::RUN_NORMAL: begin
            if (soft_restart) begin
               run_state_d = ext_status_pkg::RUN_RESTART;  // [R7]
            end
         end
         default: begin
            run_state_d = ext_status_pkg::RUN_RESTART;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_state_q <= ext_status_pkg::RUN_RESTART;  // [R7]
      end else begin
         run_state_q <= run_state_d;
      end
   end

   assign restart_cleared = (run_state_q == ext_status_pkg::RUN_RESTART) &&
                            (run_state_d == ext_status_pkg::RUN_NORMAL);

   // Assemble the word; unlisted bits stay zero
   always_comb begin
      status_word_d = 32'h0;  // [R8]
      status_word_d[ext_status_pkg::BIT_GEN_FAULT] = gen_fault_q;
      status_word_d[ext_status_pkg::BIT_HEAT_CRIT] = heat_crit_q;
      status_word_d[ext_status_pkg::BIT_HEAT_ON]   = heat_on_q;
      status_word_d[ext_status_pkg::BIT_STATIC]    = static_fault_q;
      status_word_d[ext_status_pkg::FILL_MSB:ext_status_pkg::FILL_LSB] = fill_q;
      status_word_d[ext_status_pkg::BIT_RESTART] =
         (run_state_q == ext_status_pkg::RUN_RESTART);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_word_q <= ext_status_pkg::RST_STATUS_WORD;
      end else begin
         status_word_q <= status_word_d;
      end
   end

   assign status_word = status_word_q;

   // Interrupt events: rising faults, restart flag drop, heater change
   always_comb begin
      irq_event = '0;
      irq_event[ext_status_pkg::IRQ_GEN_FAULT]   = gen_fault_d && !gen_fault_q;
      irq_event[ext_status_pkg::IRQ_STATIC]      = static_fault_d && !static_fault_q;
      irq_event[ext_status_pkg::IRQ_RESTART_CLR] = restart_cleared;
      irq_event[ext_status_pkg::IRQ_HEAT_CHG]    = heater_sync_q != heat_on_q;
   end

   // Write decode for the data phase
   assign wr_irq_status = wr_pend_q && (wr_addr_q == ext_status_pkg::OFS_IRQ_STATUS);
   assign wr_irq_mask   = wr_pend_q && (wr_addr_q == ext_status_pkg::OFS_IRQ_MASK);
   assign wr_control    = wr_pend_q && (wr_addr_q == ext_status_pkg::OFS_CONTROL);

   assign irq_clear = wr_irq_status ? hwdata[ext_status_pkg::IRQ_WIDTH-1:0] : '0;

   // A new event outranks a clear in the same cycle
   assign irq_status_d = (irq_status_q & ~irq_clear) | irq_event;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= irq_status_d;
      end
   end

   assign irq_mask_d = wr_irq_mask ? hwdata[ext_status_pkg::IRQ_WIDTH-1:0] : irq_mask_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask_q <= ext_status_pkg::RST_IRQ_MASK;
      end else begin
         irq_mask_q <= irq_mask_d;
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // AHB-Lite slave, zero wait states, always OKAY
   assign acc_valid = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h0;
      end else begin
         // Writes outside the decoded window are dropped, as reads return zero
         wr_pend_q <= acc_valid && hwrite && (haddr[31:8] == 24'h0);
         if (acc_valid) begin
            wr_addr_q <= haddr[7:0];
         end
      end
   end

   assign soft_restart = wr_control && hwdata[ext_status_pkg::CTRL_SOFT_RESTART];

   // Unmapped and write-only offsets read as zero; a write in its data phase
   // is already visible, so a read right behind it returns the new value
   always_comb begin
      rd_mux = 32'h0;
      if (haddr[31:8] == 24'h0) begin
         case (haddr[7:0])
            ext_status_pkg::OFS_STATUS_WORD: rd_mux = status_word_q;
            ext_status_pkg::OFS_IRQ_STATUS:  rd_mux = {28'h0, irq_status_d};
            ext_status_pkg::OFS_IRQ_MASK:    rd_mux = {28'h0, irq_mask_d};
            default:                         rd_mux = 32'h0;
         endcase
      end
   end

   // Read data is captured at the address phase and held for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0;
      end else if (acc_valid && !hwrite) begin
         hrdata_q <= rd_mux;
      end
   end

   assign hrdata = hrdata_q;

endmodule

// ### rtl/persist_timer.sv
// Counts consecutive cycles of a condition and flags when a limit is reached
`timescale 1ns/10ps
module persist_timer #(
   parameter logic [ext_status_pkg::TIMER_W-1:0] LIMIT = 40'h1
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Condition and result
   timer_if.timer   tif
);

   logic [ext_status_pkg::TIMER_W-1:0] count_q;

   // Restarts from zero whenever the condition drops; saturates at the limit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= '0;
      end else if (!tif.run) begin
         count_q <= '0;
      end else if (count_q != LIMIT) begin
         count_q <= count_q + 40'h1;
      end
   end

   assign tif.expired = tif.run && (count_q == LIMIT);

endmodule

// ### rtl/timer_if.sv
// Link between the status block and one persistence timer
`timescale 1ns/10ps
interface timer_if;
   logic run;
   logic expired;

   modport owner (output run, input expired);
   modport timer (input run, output expired);
endinterface
